// ==== cold_fault_defs.svh ====
`ifndef COLD_FAULT_DEFS_SVH
`define COLD_FAULT_DEFS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define CFA_OFFSET        8'h54
`define CFA_RESET         8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define CFA_MODE_HI       7
`define CFA_MODE_LO       6
`define CFA_RETRY_HI      5
`define CFA_RETRY_LO      3
`define CFA_DELAY_HI      2
`define CFA_DELAY_LO      0

// ****************************************************************
// Retry codes
// ****************************************************************
`define CFA_RETRY_NONE    3'h0
`define CFA_RETRY_ENDLESS 3'h7

// ****************************************************************
// Timing
// ****************************************************************
`define CFA_CLK_HZ        25000000
`define CFA_RUN_UNIT_MS   80
`define CFA_RETRY_UNIT_MS 32
`define CFA_PRESCALE_W    21

`endif

// ==== cold_fault_pkg.sv ====
package cold_fault_pkg;

    typedef enum logic [1:0] {
        MODE_IGNORE,
        MODE_RUN_THEN_RETRY,
        MODE_OFF_THEN_RETRY,
        MODE_OFF_WHILE_FAULT
    } fault_mode_e;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RUN,
        ST_RUN_DELAY,
        ST_WAIT,
        ST_TRYING,
        ST_DROP,
        ST_LATCHED,
        ST_HOLD
    } seq_state_e;

    typedef logic [2:0] field3_t;

endpackage

// ==== delay_if.sv ====
`timescale 1ns/10ps

interface delay_if;
    logic                     start;
    logic                     retry_unit;
    cold_fault_pkg::field3_t  units;
    logic                     done;

    modport ctrl  (output start, output retry_unit, output units, input done);
    modport timer (input start, input retry_unit, input units, output done);
endinterface

// ==== delay_timer.sv ====
`timescale 1ns/10ps
`include "cold_fault_defs.svh"

module delay_timer #(
    parameter int unsigned RUN_UNIT_CYC   = `CFA_RUN_UNIT_MS * (`CFA_CLK_HZ / 1000),
    parameter int unsigned RETRY_UNIT_CYC = `CFA_RETRY_UNIT_MS * (`CFA_CLK_HZ / 1000)
) (
    input  wire logic  ref_clk,
    input  wire logic  rstn,
    delay_if.timer     tmr
);

    logic [`CFA_PRESCALE_W-1:0] pre;
    logic [`CFA_PRESCALE_W-1:0] limit;
    logic                       unit_sel;
    cold_fault_pkg::field3_t    left;
    logic                       busy;

    // Unit length is latched at start so a later mode change cannot stretch a delay
    assign limit = unit_sel ? `CFA_PRESCALE_W'(RETRY_UNIT_CYC - 1)
                            : `CFA_PRESCALE_W'(RUN_UNIT_CYC - 1);
    assign tmr.done = busy && (left == 3'h0);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            busy     <= 1'b0;
            left     <= 3'h0;
            pre      <= '0;
            unit_sel <= 1'b0;
        end else if (tmr.start) begin
            busy     <= 1'b1;
            left     <= tmr.units;
            pre      <= '0;
            unit_sel <= tmr.retry_unit;
        end else if (busy) begin
            if (left == 3'h0) begin
                busy <= 1'b0;
            end else if (pre == limit) begin
                pre  <= '0;
                left <= left - 3'h1;
            end else begin
                pre  <= pre + `CFA_PRESCALE_W'(1);
            end
        end
    end

endmodule

// ==== undertemp_fault_response.sv ====
`timescale 1ns/10ps
`include "cold_fault_defs.svh"

// Overview of operation
// - Any mode: fault pulls alert line low and sets the status fault flag.
// - Bits 7:6 pick the reaction; code 00 keeps running untouched.
// - Code 01 runs for delay times run unit, then retries if fault remains.
// - Code 10 disables the output at once, then follows the retry field.
// - Code 11 holds output off while fault lasts, resumes when it goes.
// - Bits 5:3 set the number of restart attempts after a shutdown.
// - Retry 000 makes no attempt; output stays off until fault cleared.
// - Retry 001 tries once; on failure output stays off until cleared.
// - Spacing between attempt starts is delay field times the retry unit plus two cycles.
// - Codes 010 to 101 give two to five attempts before giving up.
// - Code 110 gives six attempts; 111 retries without limit.
// - Delay unit is 80 ms while running, 32 ms between restart attempts.

module undertemp_fault_response #(
    parameter int unsigned RUN_UNIT_CYC   = `CFA_RUN_UNIT_MS * (`CFA_CLK_HZ / 1000),
    parameter int unsigned RETRY_UNIT_CYC = `CFA_RETRY_UNIT_MS * (`CFA_CLK_HZ / 1000)
) (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  cmd_code,
    input  wire logic        cmd_wr,
    input  wire logic [7:0]  cmd_wdata,
    output logic      [7:0]  cmd_rdata,
    input  wire logic        fault_in,
    input  wire logic        output_on_cmd,
    input  wire logic        clear_faults,
    input  wire logic        alert_line_i,
    output logic             alert_line_o,
    output logic             alert_line_oe,
    output logic             output_enable,
    output logic             fault_flag,
    output logic             gave_up,
    output logic      [2:0]  attempt_count
);

    // ****************************************************************
    // Configuration register
    // ****************************************************************
    logic [7:0]                  cold_fault_action;
    cold_fault_pkg::fault_mode_e mode;
    cold_fault_pkg::field3_t     retry_code;
    cold_fault_pkg::field3_t     delay_code;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cold_fault_action <= `CFA_RESET;
        end else if (cmd_wr && (cmd_code == `CFA_OFFSET)) begin
            cold_fault_action <= cmd_wdata;
        end
    end

    // ****************************************************************
    // Register read path
    // ****************************************************************
    // Unmapped command codes read as zero
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cmd_rdata <= 8'h00;
        end else if (cmd_code == `CFA_OFFSET) begin
            cmd_rdata <= cold_fault_action;
        end else begin
            cmd_rdata <= 8'h00;
        end
    end

    // ****************************************************************
    // Field decode
    // ****************************************************************
    assign mode       = cold_fault_pkg::fault_mode_e'(
                        cold_fault_action[`CFA_MODE_HI:`CFA_MODE_LO]);
    assign retry_code = cold_fault_action[`CFA_RETRY_HI:`CFA_RETRY_LO];
    assign delay_code = cold_fault_action[`CFA_DELAY_HI:`CFA_DELAY_LO];

    // ****************************************************************
    // Fault flag and alert
    // ****************************************************************
    logic fault_prev;
    logic fault_rise;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            fault_prev <= 1'b0;
        end else begin
            fault_prev <= fault_in;
        end
    end

    assign fault_rise = fault_in && !fault_prev;

    // Set wins over a clear in the same cycle so no fault is lost
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            fault_flag <= 1'b0;
        end else if (fault_rise) begin
            fault_flag <= 1'b1;
        end else if (clear_faults) begin
            fault_flag <= 1'b0;
        end
    end

    // Open-drain alert: only ever pulled low, released otherwise
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            alert_line_o  <= 1'b0;
            alert_line_oe <= 1'b0;
        end else begin
            alert_line_o  <= 1'b0;
            alert_line_oe <= fault_flag || fault_rise;
        end
    end

    // ****************************************************************
    // Delay timer
    // ****************************************************************
    delay_if tmr ();

    delay_timer #(
        .RUN_UNIT_CYC   (RUN_UNIT_CYC),
        .RETRY_UNIT_CYC (RETRY_UNIT_CYC)
    ) u_timer (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .tmr     (tmr.timer)
    );

    // ****************************************************************
    // Response sequencer
    // ****************************************************************
    cold_fault_pkg::seq_state_e state;
    cold_fault_pkg::seq_state_e next_state;
    logic                       exhausted;
    logic                       start_run;
    logic                       start_retry;
    logic                       count_up;
    logic                       count_clr;

    // Endless retry never runs out; count saturates harmlessly there
    assign exhausted = (retry_code != `CFA_RETRY_ENDLESS) &&
                       (attempt_count >= retry_code);

    always_comb begin
        next_state  = state;
        start_run   = 1'b0;
        start_retry = 1'b0;
        count_up    = 1'b0;
        count_clr   = 1'b0;
        case (state)
            cold_fault_pkg::ST_IDLE: begin
                count_clr = 1'b1;
                if (output_on_cmd) begin
                    next_state = cold_fault_pkg::ST_RUN;
                end
            end
            cold_fault_pkg::ST_RUN: begin
                if (!fault_in) begin
                    count_clr = 1'b1;
                end else begin
                    case (mode)
                        cold_fault_pkg::MODE_IGNORE: begin
                            next_state = cold_fault_pkg::ST_RUN;
                        end
                        cold_fault_pkg::MODE_RUN_THEN_RETRY: begin
                            start_run  = 1'b1;
                            next_state = cold_fault_pkg::ST_RUN_DELAY;
                        end
                        cold_fault_pkg::MODE_OFF_THEN_RETRY: begin
                            if (retry_code == `CFA_RETRY_NONE) begin
                                next_state = cold_fault_pkg::ST_LATCHED;
                            end else begin
                                start_retry = 1'b1;
                                next_state  = cold_fault_pkg::ST_WAIT;
                            end
                        end
                        cold_fault_pkg::MODE_OFF_WHILE_FAULT: begin
                            next_state = cold_fault_pkg::ST_HOLD;
                        end
                        default: begin
                            next_state = cold_fault_pkg::ST_RUN;
                        end
                    endcase
                end
            end
            cold_fault_pkg::ST_RUN_DELAY: begin
                if (!fault_in) begin
                    count_clr  = 1'b1;
                    next_state = cold_fault_pkg::ST_RUN;
                end else if (tmr.done) begin
                    if (retry_code == `CFA_RETRY_NONE) begin
                        next_state = cold_fault_pkg::ST_LATCHED;
                    end else begin
                        start_retry = 1'b1;
                        next_state  = cold_fault_pkg::ST_WAIT;
                    end
                end
            end
            cold_fault_pkg::ST_WAIT: begin
                // Output stays off for one full spacing before the first attempt
                if (tmr.done) begin
                    start_retry = 1'b1;
                    count_up    = 1'b1;
                    next_state  = cold_fault_pkg::ST_TRYING;
                end
            end
            cold_fault_pkg::ST_TRYING: begin
                if (tmr.done) begin
                    if (!fault_in) begin
                        count_clr  = 1'b1;
                        next_state = cold_fault_pkg::ST_RUN;
                    end else if (exhausted) begin
                        next_state = cold_fault_pkg::ST_LATCHED;
                    end else begin
                        next_state = cold_fault_pkg::ST_DROP;
                    end
                end
            end
            cold_fault_pkg::ST_DROP: begin
                // One cycle off between a failed attempt and the next
                start_retry = 1'b1;
                count_up    = 1'b1;
                next_state  = cold_fault_pkg::ST_TRYING;
            end
            cold_fault_pkg::ST_LATCHED: begin
                if (clear_faults && !fault_in) begin
                    count_clr  = 1'b1;
                    next_state = cold_fault_pkg::ST_RUN;
                end
            end
            cold_fault_pkg::ST_HOLD: begin
                if (!fault_in) begin
                    next_state = cold_fault_pkg::ST_RUN;
                end
            end
            default: begin
                next_state = cold_fault_pkg::ST_IDLE;
            end
        endcase
        // Command off overrides every fault state and ends any retry run
        if (!output_on_cmd) begin
            next_state  = cold_fault_pkg::ST_IDLE;
            start_run   = 1'b0;
            start_retry = 1'b0;
            count_up    = 1'b0;
            count_clr   = 1'b1;
        end
    end

    // ****************************************************************
    // Timer requests
    // ****************************************************************
    // Spacing runs two cycles past the nominal count: one for done, one off
    assign tmr.start      = start_run || start_retry;
    assign tmr.retry_unit = start_retry;
    assign tmr.units      = delay_code;

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state <= cold_fault_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // Attempt counter
    // ****************************************************************
    // Saturates at seven so endless retry can never wrap to a small count
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            attempt_count <= 3'h0;
        end else if (count_clr) begin
            attempt_count <= 3'h0;
        end else if (count_up && (attempt_count != 3'h7)) begin
            attempt_count <= attempt_count + 3'h1;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Outputs follow next_state so they move on the same edge as the state
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            output_enable <= 1'b0;
        end else begin
            output_enable <= (next_state == cold_fault_pkg::ST_RUN) ||
                             (next_state == cold_fault_pkg::ST_RUN_DELAY) ||
                             (next_state == cold_fault_pkg::ST_TRYING);
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            gave_up <= 1'b0;
        end else begin
            gave_up <= (next_state == cold_fault_pkg::ST_LATCHED);
        end
    end

endmodule

// ==== pmbus_host.sv ====
`timescale 1ns/10ps
// ****************************************************************
// Host side of the command bus and the alert wire
// ****************************************************************
module pmbus_host (
    input  wire logic       ref_clk,
    output logic      [7:0] cmd_code,
    output logic            cmd_wr,
    output logic      [7:0] cmd_wdata,
    input  wire logic [7:0] cmd_rdata,
    input  wire logic       alert_line_o,
    input  wire logic       alert_line_oe,
    output logic            alert_line
);
    // Pull-up on the open-drain alert wire
    assign alert_line = alert_line_oe ? alert_line_o : 1'b1;
    initial begin
        cmd_code  = 8'h00;
        cmd_wr    = 1'b0;
        cmd_wdata = 8'h00;
    end
    task automatic write_reg(input logic [7:0] code, input logic [7:0] data);
        @(negedge ref_clk);
        cmd_code  = code;
        cmd_wdata = data;
        cmd_wr    = 1'b1;
        @(negedge ref_clk);
        cmd_wr    = 1'b0;
        // Stale data inverted so a late capture shows up
        cmd_wdata = ~data;
    endtask
    task automatic read_reg(input logic [7:0] code, output logic [7:0] data);
        @(negedge ref_clk);
        cmd_code = code;
        @(posedge ref_clk);
        @(negedge ref_clk);
        data = cmd_rdata;
    endtask
endmodule

// ==== undertemp_fault_response_assertions.sv ====
`timescale 1ns/10ps
module cold_fault_checker (
    input wire logic       ref_clk,
    input wire logic       rstn,
    input wire logic [7:0] cmd_code,
    input wire logic       cmd_wr,
    input wire logic [7:0] cmd_wdata,
    input wire logic [7:0] cmd_rdata,
    input wire logic       fault_in,
    input wire logic       output_on_cmd,
    input wire logic       alert_line_o,
    input wire logic       alert_line_oe,
    input wire logic       output_enable,
    input wire logic       fault_flag,
    input wire logic       gave_up,
    input wire logic [2:0] attempt_count
);
    // ****************************************************************
    // Shadow of the response byte
    // ****************************************************************
    logic [7:0] shadow;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            shadow <= 8'h00;
        end else if (cmd_wr && cmd_code == 8'h54) begin
            shadow <= cmd_wdata;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence s_fault_edge;
        $rose(fault_in);
    endsequence
    sequence s_flag_up;
        ##[1:2] fault_flag;
    endsequence
    chk_flag_set: assert property (s_fault_edge |-> s_flag_up)
        else $error("fault flag not set");
    chk_alert_low: assert property (fault_flag |-> alert_line_oe && !alert_line_o)
        else $error("alert not pulled low");
    chk_ignore_runs: assert property (shadow[7:6] == 2'b00 && output_enable && output_on_cmd
        && !cmd_wr |=> output_enable)
        else $error("output dropped in ignore mode");
    chk_disable_now: assert property (shadow[7:6] == 2'b10 && fault_in && output_enable
        && attempt_count == 3'h0 |-> ##[1:2] !output_enable)
        else $error("output not disabled");
    chk_resume_on: assert property (shadow[7:6] == 2'b11 && $fell(fault_in) && output_on_cmd
        |-> ##[1:3] output_enable)
        else $error("output not resumed");
    chk_giveup_count: assert property ($rose(gave_up) |-> attempt_count == shadow[5:3])
        else $error("attempt count wrong at give up");
    chk_latched_off: assert property (gave_up |-> !output_enable)
        else $error("output on while latched");
    chk_count_clear: assert property (!output_on_cmd [*2] |-> attempt_count == 3'h0)
        else $error("attempt count not cleared");
    chk_read_back: assert property (cmd_code == 8'h54 |=> cmd_rdata == $past(shadow))
        else $error("read data mismatch");
endmodule

// ==== tb_undertemp_fault_response.sv ====
`timescale 1ns/10ps
module tb_undertemp_fault_response;
    logic       ref_clk       = 1'b0;
    logic       rstn          = 1'b0;
    logic       fault_in      = 1'b0;
    logic       output_on_cmd = 1'b0;
    logic       clear_faults  = 1'b0;
    logic [7:0] cmd_code, cmd_wdata, cmd_rdata, rd;
    logic       cmd_wr, alert_line, alert_line_o, alert_line_oe;
    logic       output_enable, fault_flag, gave_up;
    logic [2:0] attempt_count;
    int         err_total   = 0;
    int         comparisons = 0;
    int         cycles      = 0;
    int         s;
    // ****************************************************************
    // Clock, hang guard, instances
    // ****************************************************************
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_total++;
            stop_test();
        end
    end
    // Short units keep each retry episode to a few dozen cycles
    undertemp_fault_response #(.RUN_UNIT_CYC(20), .RETRY_UNIT_CYC(8)) dut_u (
        .ref_clk(ref_clk), .rstn(rstn), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
        .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .fault_in(fault_in),
        .output_on_cmd(output_on_cmd), .clear_faults(clear_faults),
        .alert_line_i(alert_line), .alert_line_o(alert_line_o), .alert_line_oe(alert_line_oe),
        .output_enable(output_enable), .fault_flag(fault_flag), .gave_up(gave_up),
        .attempt_count(attempt_count));
    pmbus_host host_u (
        .ref_clk(ref_clk), .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata),
        .cmd_rdata(cmd_rdata), .alert_line_o(alert_line_o), .alert_line_oe(alert_line_oe),
        .alert_line(alert_line));
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic recover();
        fault_in = 1'b0;
        step(2);
        clear_faults = 1'b1;
        step(1);
        clear_faults = 1'b0;
        output_on_cmd = 1'b0;
        step(2);
        check(attempt_count, 8'h00);
        check(alert_line, 8'h01);
        output_on_cmd = 1'b1;
        step(4);
        check(output_enable, 8'h01);
    endtask
    // Counts restarts until give up or maxs starts, checking start spacing
    task automatic watch(input int d, input int maxs, output int starts);
        int lim = 0;
        int last = 0;
        logic prev = output_enable;
        starts = 0;
        while (gave_up !== 1'b1 && starts < maxs && lim < 400) begin
            step(1);
            lim++;
            if (output_enable === 1'b1 && prev === 1'b0) begin
                if (starts > 0) check(8'(lim - last >= d * 8 && lim - last <= d * 8 + 3), 8'h01);
                starts++;
                last = lim;
            end
            prev = output_enable;
        end
    endtask
    task automatic stop_test();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reg();
        host_u.read_reg(8'h54, rd);
        check(rd, 8'h00);
        host_u.write_reg(8'h54, 8'ha5);
        host_u.write_reg(8'h55, 8'h3c);
        host_u.read_reg(8'h54, rd);
        check(rd, 8'ha5);
        host_u.read_reg(8'h55, rd);
        check(rd, 8'h00);
        $display("test reg done");
    endtask
    task automatic t_modes();
        host_u.write_reg(8'h54, 8'h07);
        fault_in = 1'b1;
        repeat (60) begin
            step(1);
            check(output_enable, 8'h01);
        end
        check(fault_flag, 8'h01);
        check(alert_line, 8'h00);
        recover();
        host_u.write_reg(8'h54, 8'hc0);
        fault_in = 1'b1;
        step(3);
        check(output_enable, 8'h00);
        check(alert_line, 8'h00);
        fault_in = 1'b0;
        step(3);
        check(output_enable, 8'h01);
        recover();
        $display("test modes done");
    endtask
    task automatic t_run01();
        host_u.write_reg(8'h54, 8'h4a);
        fault_in = 1'b1;
        step(36);
        check(output_enable, 8'h01);
        step(10);
        check(output_enable, 8'h00);
        watch(2, 8, s);
        check(8'(s), 8'h01);
        recover();
        $display("test run then retry done");
    endtask
    task automatic t_retry(input logic [2:0] n);
        host_u.write_reg(8'h54, {2'b10, n, 3'h2});
        fault_in = 1'b1;
        step(2);
        check(output_enable, 8'h00);
        watch(2, 8, s);
        check(8'(s), 8'(n));
        check(attempt_count, 8'(n));
        check(gave_up, 8'h01);
        recover();
        $display("test retry %0d done", n);
    endtask
    task automatic t_endless();
        host_u.write_reg(8'h54, 8'hba);
        fault_in = 1'b1;
        watch(2, 7, s);
        check(8'(s), 8'h07);
        check(gave_up, 8'h00);
        fault_in = 1'b0;
        step(30);
        check(output_enable, 8'h01);
        check(attempt_count, 8'h00);
        $display("test endless done");
    endtask
    initial begin
        step(8);
        rstn = 1'b1;
        t_reg();
        output_on_cmd = 1'b1;
        step(4);
        t_modes();
        t_run01();
        for (int n = 0; n < 7; n++) begin
            t_retry(3'(n));
        end
        t_endless();
        stop_test();
    end
endmodule

bind undertemp_fault_response cold_fault_checker chk_u (
    .ref_clk(ref_clk), .rstn(rstn), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
    .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .fault_in(fault_in),
    .output_on_cmd(output_on_cmd), .alert_line_o(alert_line_o), .alert_line_oe(alert_line_oe),
    .output_enable(output_enable), .fault_flag(fault_flag), .gave_up(gave_up),
    .attempt_count(attempt_count));
